// file: core/sfr_pkg.sv
// shared constants and carrier types of the special function register bank
package sfr_pkg;

    // number of storage slots; slot 43 is the second owner of the shared irq byte
    localparam int SFR_NSLOT = 48;

    // slot numbers with special reset or access behaviour
    localparam int SL_CSP_MODE = 16;
    localparam int SL_TRIM_1 = 18;
    localparam int SL_TRIM_4 = 21;
    localparam int SL_TRIM_6 = 22;
    localparam int SL_TRIM_7 = 23;
    localparam int SL_VDET_1 = 24;
    localparam int SL_VDET_2 = 25;
    localparam int SL_VMON_1 = 26;
    localparam int SL_VMON_0 = 28;
    localparam int SL_SSU_IRQ = 33;
    localparam int SL_IIC_IRQ = 43;
    localparam int SL_OPTION = 47;

    // register index of every slot, in slot order (the bus address is the index itself)
    localparam logic [SFR_NSLOT-1:0][15:0] SFR_INDEX = {
        16'hFFFF, 16'h01B7, 16'h01B5, 16'h01B3, 16'h004F, 16'h005D,
        16'h005A, 16'h0059, 16'h0058, 16'h0056, 16'h0054, 16'h0053,
        16'h0052, 16'h0051, 16'h004F, 16'h004E, 16'h004D, 16'h004A,
        16'h0047, 16'h0038, 16'h0037, 16'h0036, 16'h0032, 16'h0031,
        16'h002C, 16'h002B, 16'h0029, 16'h0028, 16'h0025, 16'h0024,
        16'h0023, 16'h001C, 16'h0016, 16'h0015, 16'h0014, 16'h0013,
        16'h0012, 16'h0011, 16'h0010, 16'h000F, 16'h000E, 16'h000D,
        16'h000C, 16'h000A, 16'h0007, 16'h0006, 16'h0005, 16'h0004};

    // plain reset value of every slot; undefined bits are cleared
    localparam logic [SFR_NSLOT-1:0][7:0] SFR_RESET = {
        8'hFF, 8'h01, 8'h80, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h08,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1F,
        8'h00, 8'h00, 8'h04, 8'h00, 8'h20, 8'h68, 8'h00, 8'h00};

    // option word fields and state of an unprogrammed word
    localparam int OPT_MON0_BIT = 5;
    localparam int OPT_MON1_BIT = 6;
    localparam int OPT_CSP_INIT_BIT = 7;
    localparam logic [7:0] OPT_ERASED = 8'hFF;

    // selectable reset values of the voltage and protection registers
    localparam logic [7:0] RV_ZERO = 8'h00;
    localparam logic [7:0] RV_VDET2_ND_ON = 8'h20;
    localparam logic [7:0] RV_VDET2_JK_ON = 8'h40;
    localparam logic [7:0] RV_VMON_ON = 8'h41;
    localparam logic [7:0] RV_VMON1_ND = 8'h08;
    localparam logic [7:0] RV_VDET1 = 8'h08;
    localparam logic [7:0] RV_CSP_ON = 8'h80;
    localparam logic [7:0] VMON1_KEEP_MASK = 8'h0C;

    // avalon response codes
    localparam logic [1:0] AV_OKAY = 2'h0;
    localparam logic [1:0] AV_DECERR = 2'h3;

    // reset causes, each a one-cycle pulse from the reset controller
    typedef struct packed {
        logic hw;
        logic por;
        logic wdt;
        logic sw;
        logic vmon0;
        logic vmon1;
        logic vmon2;
    } sfr_cause_type;

    // avalon request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [15:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } sfr_av_req_type;

    // avalon answer to the master
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic [1:0] response;
    } sfr_av_rsp_type;

    // handshake states
    typedef enum logic [0:0] {AV_IDLE = 1'b0, AV_ACK = 1'b1} sfr_av_state_type;

endpackage

// file: core/sfr_av_slave.sv
// avalon-mm handshake with one wait state and registered read data
`timescale 1ns/1ps
`default_nettype none
module sfr_av_slave import sfr_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bus side
    input wire sfr_av_req_type req,
    output var sfr_av_rsp_type rsp,
    // decoded result of the current address
    input wire logic hit,
    input wire logic [7:0] rd_byte,
    // one-cycle strobe when the request completes
    output logic commit
);
    // all state in one struct
    typedef struct packed {
        sfr_av_state_type st;
        logic [31:0] rdata;
        logic [1:0] resp;
    } sfr_av_q_type;

    sfr_av_q_type q_q;
    sfr_av_q_type q_d;
    logic active;

    assign active = req.read | req.write;
    // the master sees its answer on the edge after the request is taken
    assign commit = active && (q_q.st == AV_ACK);
    assign rsp.waitrequest = active && (q_q.st != AV_ACK);
    assign rsp.readdata = q_q.rdata;
    assign rsp.response = q_q.resp;

    // next state; data is captured while waiting so it stands at the ack edge
    always_comb begin
        q_d = q_q;
        case (q_q.st)
            AV_IDLE: begin
                if (active) begin
                    q_d.st = AV_ACK;
                    q_d.rdata = {24'h000000, (hit && req.read) ? rd_byte : 8'h00};
                    q_d.resp = hit ? AV_OKAY : AV_DECERR;
                end
            end
            AV_ACK: begin
                q_d.st = AV_IDLE;
            end
            default: begin
                q_d.st = AV_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q_q <= '{st: AV_IDLE, rdata: 32'h00000000, resp: AV_OKAY};
        end else begin
            q_q <= q_d;
        end
    end

    // a taken request is answered exactly one edge later
    sequence seq_taken;
        active && rsp.waitrequest;
    endsequence
    AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
        seq_taken |=> !rsp.waitrequest && commit)
        else $error("request not answered after one wait state");
endmodule
`default_nettype wire

// file: core/sfr_reset_select.sv
// picks reset values of the voltage, monitor and protection registers by cause and option word
`timescale 1ns/1ps
`default_nettype none
module sfr_reset_select import sfr_pkg::*; (
    // variant: 1 for the variant with monitor 0, 0 for the other one
    input wire logic nd_variant,
    // cause of the reset and option word
    input wire sfr_cause_type cause,
    input wire logic [7:0] option,
    // present contents
    input wire logic [7:0] vdet1_cur,
    input wire logic [7:0] vdet2_cur,
    input wire logic [7:0] vmon1_cur,
    input wire logic [7:0] vmon0_cur,
    // values after the reset
    output logic [7:0] vdet1_rst,
    output logic [7:0] vdet2_rst,
    output logic [7:0] vmon1_rst,
    output logic [7:0] vmon0_rst,
    output logic [7:0] csp_rst
);
    logic full;
    logic on;
    logic [7:0] vmon1_base;

    // only hardware, power-on and the variant's own monitor reload the detectors
    always_comb begin
        full = cause.hw | cause.por | (nd_variant ? cause.vmon0 : cause.vmon1);
        if (nd_variant) begin
            on = cause.por | cause.vmon0 | (cause.hw & ~option[OPT_MON0_BIT]);
        end else begin
            on = cause.por | cause.vmon1 | (cause.hw & ~option[OPT_MON1_BIT]);
        end
        vdet1_rst = full ? RV_VDET1 : vdet1_cur;
        if (!full) begin
            vdet2_rst = vdet2_cur;
        end else if (on) begin
            vdet2_rst = nd_variant ? RV_VDET2_ND_ON : RV_VDET2_JK_ON;
        end else begin
            vdet2_rst = RV_ZERO;
        end
        vmon1_base = nd_variant ? RV_VMON1_ND : (on ? RV_VMON_ON : RV_ZERO);
        // soft resets only touch the bits outside the kept pair
        vmon1_rst = full ? vmon1_base
                         : ((vmon1_cur & VMON1_KEEP_MASK) | (vmon1_base & ~VMON1_KEEP_MASK));
        vmon0_rst = full ? (on ? RV_VMON_ON : RV_ZERO) : vmon0_cur;
        csp_rst = option[OPT_CSP_INIT_BIT] ? RV_ZERO : RV_CSP_ON;
    end
endmodule
`default_nettype wire

// file: core/sfr_bank.sv
// special function register bank with cause-dependent reset values
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module sfr_bank import sfr_pkg::*; #(
    // 1 selects the variant with monitor 0 and all trim registers
    parameter bit ND_VARIANT = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // avalon-mm slave, word index addressing
    input wire sfr_av_req_type av_req,
    output var sfr_av_rsp_type av_rsp,
    // reset cause pulses from the reset controller
    input wire sfr_cause_type rst_cause,
    // factory trim bytes for trims 1, 4, 6, 7 in that order
    input wire logic [3:0][7:0] trim_factory,
    // external flash programmer port for the option word
    input wire logic prog_we,
    input wire logic [7:0] prog_data,
    // serial function select from the pin mode register
    input wire logic serial_function_select,
    // register contents for the peripherals
    output logic [SFR_NSLOT-1:0][7:0] sfr_regs
);
    // all state: one byte per slot
    typedef struct packed {
        logic [SFR_NSLOT-1:0][7:0] regs;
    } sfr_bank_q_type;

    sfr_bank_q_type st_q; // registered state
    sfr_bank_q_type st_d; // next state
    sfr_cause_type cause_eff; // cause seen by the reset selector
    logic cause_any; // some reset cause this cycle
    logic [6:0] dec; // hit flag and slot
    logic hit; // address maps to a register
    logic [5:0] slot; // selected slot
    logic commit; // bus request completes now
    logic wr_ok; // write may update the slot
    logic [7:0] vdet1_rst; // reset values from the selector
    logic [7:0] vdet2_rst;
    logic [7:0] vmon1_rst;
    logic [7:0] vmon0_rst;
    logic [7:0] csp_rst;
    logic [7:0] opt_eff; // option word the selector sees

    // index to slot; reserved locations of the variant do not decode
    function automatic logic [6:0] sfr_decode(input logic [15:0] idx, input logic nd,
                                             input logic iic_sel);
        logic [6:0] res;
        res = 7'h00;
        for (int i = 0; i < SFR_NSLOT; i++) begin
            // the second owner of the shared byte is reached by the select bit only
            if (i != SL_IIC_IRQ && SFR_INDEX[i] == idx) begin
                res = {1'b1, 6'(i)};
            end
        end
        // trims 4, 6, 7 and monitor 0 control are reserved in the other variant
        if (!nd && (res[5:0] == 6'(SL_TRIM_4) || res[5:0] == 6'(SL_TRIM_6) ||
                    res[5:0] == 6'(SL_TRIM_7) || res[5:0] == 6'(SL_VMON_0))) begin
            res = 7'h00;
        end
        if (res[6] && res[5:0] == 6'(SL_SSU_IRQ) && iic_sel) begin
            res = {1'b1, 6'(SL_IIC_IRQ)};
        end
        return res;
    endfunction

    // power-on stands in for the cause while the reset pin is low
    always_comb begin
        cause_eff = rst_cause;
        if (!rst_b) begin
            cause_eff = '{hw: 1'b0, por: 1'b1, wdt: 1'b0, sw: 1'b0,
                          vmon0: 1'b0, vmon1: 1'b0, vmon2: 1'b0};
        end
    end

    assign cause_any = |rst_cause;
    // unmapped gaps answer with a decode error and read as zero
    assign dec = sfr_decode(av_req.address, ND_VARIANT, serial_function_select);
    assign hit = dec[6];
    assign slot = dec[5:0];
    // only lane 0 carries the register; the option word ignores the bus
    assign wr_ok = commit && av_req.write && hit && av_req.byteenable[0] &&
                   slot != 6'(SL_OPTION);
    assign sfr_regs = st_q.regs;
    // the pin reset reloads the erased word in the same edge, so the selector must
    // see that value too, or a one-edge reset leaves protection mode unknown
    assign opt_eff = rst_b ? st_q.regs[SL_OPTION] : OPT_ERASED;

    // bus handshake
    sfr_av_slave u_av (
        .clk(clk),
        .rst_b(rst_b),
        .req(av_req),
        .rsp(av_rsp),
        .hit(hit),
        .rd_byte(st_q.regs[slot]),
        .commit(commit)
    );

    // cause-dependent reset values
    sfr_reset_select u_rsel (
        .nd_variant(ND_VARIANT),
        .cause(cause_eff),
        .option(opt_eff),
        .vdet1_cur(st_q.regs[SL_VDET_1]),
        .vdet2_cur(st_q.regs[SL_VDET_2]),
        .vmon1_cur(st_q.regs[SL_VMON_1]),
        .vmon0_cur(st_q.regs[SL_VMON_0]),
        .vdet1_rst(vdet1_rst),
        .vdet2_rst(vdet2_rst),
        .vmon1_rst(vmon1_rst),
        .vmon0_rst(vmon0_rst),
        .csp_rst(csp_rst)
    );

    // next state: a reset of any kind beats a bus write in the same cycle
    always_comb begin
        st_d = st_q;
        if (!rst_b || cause_any) begin
            // plain registers take their table value on every cause
            st_d.regs = SFR_RESET;
            st_d.regs[SL_CSP_MODE] = csp_rst;
            st_d.regs[SL_VDET_1] = vdet1_rst;
            st_d.regs[SL_VDET_2] = vdet2_rst;
            st_d.regs[SL_VMON_1] = vmon1_rst;
            st_d.regs[SL_VMON_0] = vmon0_rst;
            // trims reload from the factory bytes rather than a constant
            st_d.regs[SL_TRIM_1] = trim_factory[0];
            st_d.regs[SL_TRIM_4] = trim_factory[1];
            st_d.regs[SL_TRIM_6] = trim_factory[2];
            st_d.regs[SL_TRIM_7] = trim_factory[3];
            // the option word lives in flash; only the pin reset reloads it
            st_d.regs[SL_OPTION] = rst_b ? st_q.regs[SL_OPTION] : OPT_ERASED;
        end else begin
            if (wr_ok) begin
                st_d.regs[slot] = av_req.writedata[7:0];
            end
            // the programmer is the only writer of the option word
            if (prog_we) begin
                st_d.regs[SL_OPTION] = prog_data;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    // ---- assertions ----
    logic soft_cause; // causes that keep the detector registers
    logic wr_slot_q; // a bus write is landing this edge
    assign soft_cause = rst_cause.sw | rst_cause.wdt | rst_cause.vmon2 |
                        (ND_VARIANT ? rst_cause.vmon1 : 1'b0);

    always_comb begin
        wr_slot_q = wr_ok;
    end

    // a soft reset leaves detection register 1 as it was
    property p_vdet1_keep;
        @(posedge clk) disable iff (!rst_b)
        soft_cause && !rst_cause.hw && !rst_cause.por && !rst_cause.vmon0 &&
        !(ND_VARIANT ? 1'b0 : rst_cause.vmon1)
        |=> $stable(st_q.regs[SL_VDET_1]) && $stable(st_q.regs[SL_VDET_2]);
    endproperty
    AST_VDET_KEEP: assert property (p_vdet1_keep)
        else $error("detection register changed by a soft reset");

    AST_VMON1_BITS: assert property (@(posedge clk) disable iff (!rst_b)
        cause_any |=> (st_q.regs[SL_VMON_1] & 8'hB2) == 8'h00 &&
        ((st_q.regs[SL_VMON_1] & VMON1_KEEP_MASK) ==
         ($past(st_q.regs[SL_VMON_1]) & VMON1_KEEP_MASK) ||
         $past(rst_cause.hw | rst_cause.por | (ND_VARIANT ? rst_cause.vmon0 : rst_cause.vmon1))))
        else $error("monitor 1 control kept bits lost");

    AST_VMON0_RSVD: assert property (@(posedge clk) disable iff (!rst_b)
        commit && !ND_VARIANT && av_req.address == SFR_INDEX[SL_VMON_0]
        |-> av_rsp.response == AV_DECERR && av_rsp.readdata == 32'h00000000)
        else $error("monitor 0 control answered in a variant without it");

    AST_VDET2_OPT_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        ND_VARIANT && rst_cause == sfr_cause_type'(7'h40) &&
        st_q.regs[SL_OPTION][OPT_MON0_BIT]
        |=> st_q.regs[SL_VDET_2] == RV_ZERO && st_q.regs[SL_VMON_0] == RV_ZERO)
        else $error("detection 2 not cleared by hardware reset");

    sequence seq_pin_release;
        !rst_b ##1 rst_b;
    endsequence
    AST_POR_VALUES: assert property (@(posedge clk)
        seq_pin_release |-> st_q.regs[SL_VDET_2] ==
        (ND_VARIANT ? RV_VDET2_ND_ON : RV_VDET2_JK_ON) &&
        st_q.regs[SL_VMON_1] == (ND_VARIANT ? RV_VMON1_ND : RV_VMON_ON))
        else $error("power-on values of the voltage registers wrong");

    AST_JK_HW_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        !ND_VARIANT && rst_cause.hw && !rst_cause.por && !rst_cause.vmon1 &&
        st_q.regs[SL_OPTION][OPT_MON1_BIT]
        |=> st_q.regs[SL_VMON_1] == RV_ZERO && st_q.regs[SL_VDET_2] == RV_ZERO)
        else $error("monitor 1 option not honoured");

    AST_CSP_INIT: assert property (@(posedge clk) disable iff (!rst_b)
        cause_any |=> st_q.regs[SL_CSP_MODE] ==
        ($past(st_q.regs[SL_OPTION][OPT_CSP_INIT_BIT]) ? RV_ZERO : RV_CSP_ON))
        else $error("protection mode reset value wrong");

    AST_OPTION_RO: assert property (@(posedge clk) disable iff (!rst_b)
        !prog_we |=> $stable(st_q.regs[SL_OPTION]))
        else $error("option word changed without the programmer");

    AST_SHARED_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        wr_slot_q && !cause_any && av_req.address == SFR_INDEX[SL_SSU_IRQ]
        |=> st_q.regs[serial_function_select ? SL_SSU_IRQ : SL_IIC_IRQ] ==
        $past(st_q.regs[serial_function_select ? SL_SSU_IRQ : SL_IIC_IRQ]))
        else $error("shared irq byte wrote the wrong owner");

    AST_TRIM_LOAD: assert property (@(posedge clk)
        seq_pin_release |-> st_q.regs[SL_TRIM_1] == $past(trim_factory[0]) &&
        st_q.regs[SL_TRIM_7] == $past(trim_factory[3]))
        else $error("trim registers not loaded from factory bytes");

    AST_BYTE_LANE: assert property (@(posedge clk) disable iff (!rst_b)
        commit && av_req.read |-> av_rsp.readdata[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
endmodule
`default_nettype wire

// file: bench/sfr_cpu_model.sv
// cpu core model: avalon-mm master making one byte access at a time
`timescale 1ns/1ps
`default_nettype none
module sfr_cpu_model import sfr_pkg::*; (
    // clock
    input wire logic clk,
    // bus to the register bank
    output var sfr_av_req_type req,
    input wire sfr_av_rsp_type rsp
);
    // idle bus from time zero, every byte lane enabled
    initial begin
        req = '0;
        req.byteenable = 4'hF;
    end

    // one transfer, entered just after a rising edge
    // only listed places are used unless the bench asks for a gap on purpose
    task automatic xfer(input logic wr, input logic [15:0] adr, input logic [7:0] wd,
                        output logic [7:0] rd, output logic [1:0] resp, output bit ok);
        int n;
        req.read <= ~wr;
        req.write <= wr;
        req.address <= adr;
        req.writedata <= {24'h000000, wd};
        n = 0;
        // request held until waitrequest is seen low at an edge
        do begin
            @(posedge clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 64);
        ok = (rsp.waitrequest === 1'b0);
        rd = rsp.readdata[7:0];
        resp = rsp.response;
        req.read <= 1'b0;
        req.write <= 1'b0;
        // idle edge so the next request is a fresh raise
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: bench/sfr_bank_tb_top.sv
// self-checking bench of the special function register bank
`timescale 1ns/1ps
`default_nettype none
module sfr_bank_tb_top import sfr_pkg::*;;
    // design inputs and outputs
    logic clk;
    logic rst_b;
    sfr_av_req_type av_req;
    sfr_av_rsp_type av_rsp;
    sfr_cause_type rst_cause;
    logic [3:0][7:0] trim_factory;
    logic prog_we;
    logic [7:0] prog_data;
    logic serial_function_select;
    logic [SFR_NSLOT-1:0][7:0] sfr_regs;
    // second variant, same bus and causes, answer unused by the master
    sfr_av_rsp_type av_rsp_jk;
    logic [SFR_NSLOT-1:0][7:0] sfr_regs_jk;
    // bookkeeping
    int failures;
    int cmp_count;
    // factory trims, arbitrary but all distinct
    localparam logic [3:0][7:0] TRIMS = {8'hC7, 8'h9B, 8'h5E, 8'h3A};
    localparam logic [3:0][15:0] TRIM_IDX = {16'h002C, 16'h002B, 16'h0029, 16'h0024};
    // cause pulses, order hw por wdt sw vmon0 vmon1 vmon2
    localparam logic [6:0] C_HW = 7'h40;
    localparam logic [3:0][6:0] SOFT = {7'h08, 7'h10, 7'h02, 7'h01};

    sfr_bank #(.ND_VARIANT(1'b1)) u_sfr_bank (
        .clk(clk), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp),
        .rst_cause(rst_cause), .trim_factory(trim_factory), .prog_we(prog_we),
        .prog_data(prog_data), .serial_function_select(serial_function_select),
        .sfr_regs(sfr_regs));

    // variant without monitor 0: its reserved places and option-chosen values
    sfr_bank #(.ND_VARIANT(1'b0)) u_sfr_bank_jk (
        .clk(clk), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp_jk),
        .rst_cause(rst_cause), .trim_factory(trim_factory), .prog_we(prog_we),
        .prog_data(prog_data), .serial_function_select(serial_function_select),
        .sfr_regs(sfr_regs_jk));

    sfr_cpu_model u_sfr_cpu_model (.clk(clk), .req(av_req), .rsp(av_rsp));

    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // counts, verdict and end of run
    task automatic wrap_up();
        $display("counts: %0d compared, %0d bad", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // compare one byte
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one bus access; a hung handshake ends the run
    task automatic bus(input logic wr, input logic [15:0] adr, input logic [7:0] wd,
                       output logic [7:0] rd, output logic [1:0] resp);
        bit ok;
        u_sfr_cpu_model.xfer(wr, adr, wd, rd, resp, ok);
        if (!ok) begin
            failures++;
            $display("BAD waitrequest at %h expected 0 seen 1", adr);
            wrap_up();
        end
    endtask

    task automatic wr(input logic [15:0] adr, input logic [7:0] wd);
        logic [7:0] q;
        logic [1:0] r;
        bus(1'b1, adr, wd, q, r);
    endtask

    // read, then compare data and response code
    task automatic rd_chk(input logic [15:0] adr, input logic [7:0] exp, input logic [1:0] rexp);
        logic [7:0] q;
        logic [1:0] r;
        bus(1'b0, adr, 8'h00, q, r);
        check($sformatf("data %h", adr), q, exp);
        check($sformatf("resp %h", adr), {6'h00, r}, {6'h00, rexp});
    endtask

    // one-cycle reset cause pulse, then one quiet edge
    task automatic cause(input logic [6:0] c);
        rst_cause <= sfr_cause_type'(c);
        @(posedge clk);
        rst_cause <= '0;
        @(posedge clk);
    endtask

    // flash programmer writes the option word
    task automatic program_option(input logic [7:0] v);
        prog_we <= 1'b1;
        prog_data <= v;
        @(posedge clk);
        prog_we <= 1'b0;
        @(posedge clk);
    endtask

    // values straight after the reset pin
    task automatic test_reset_values();
        rd_chk(16'h0006, 8'h68, AV_OKAY);
        rd_chk(16'h0007, 8'h20, AV_OKAY);
        rd_chk(16'h000C, 8'h04, AV_OKAY);
        rd_chk(16'h01B3, 8'h40, AV_OKAY);
        rd_chk(16'h01B7, 8'h01, AV_OKAY);
        rd_chk(16'h0031, 8'h08, AV_OKAY);
        rd_chk(16'h0032, 8'h20, AV_OKAY);
        rd_chk(16'h0036, 8'h08, AV_OKAY);
        rd_chk(16'h0038, 8'h41, AV_OKAY);
        check("jk resp 0038", {6'h00, av_rsp_jk.response}, {6'h00, AV_DECERR});
        check("jk vdet2 por", sfr_regs_jk[SL_VDET_2], 8'h40);
        check("jk vmon1 por", sfr_regs_jk[SL_VMON_1], 8'h41);
        rd_chk(16'h001C, 8'h00, AV_OKAY);
        rd_chk(16'hFFFF, 8'hFF, AV_OKAY);
        for (int i = 0; i < 4; i++) begin
            rd_chk(TRIM_IDX[i], TRIMS[i], AV_OKAY);
        end
        $display("test reset values done");
    endtask

    // gaps refuse; deliberate accesses outside the map
    task automatic test_gaps();
        wr(16'h0017, 8'hAA);
        rd_chk(16'h0017, 8'h00, AV_DECERR);
        rd_chk(16'h0000, 8'h00, AV_DECERR);
        rd_chk(16'h0033, 8'h00, AV_DECERR);
        $display("test gaps done");
    endtask

    // match registers as three independent bytes, back to back
    task automatic test_match_bytes();
        for (int i = 0; i < 6; i++) begin
            wr((i < 3) ? 16'h0010 + 16'(i) : 16'h0011 + 16'(i), 8'h11 * 8'(i + 1));
        end
        for (int i = 0; i < 6; i++) begin
            rd_chk((i < 3) ? 16'h0010 + 16'(i) : 16'h0011 + 16'(i), 8'h11 * 8'(i + 1), AV_OKAY);
        end
        rd_chk(16'h0013, 8'h00, AV_OKAY);
        $display("test match bytes done");
    endtask

    // option word: program cannot write it, programmer can; it picks reset values
    task automatic test_option();
        wr(16'hFFFF, 8'h00);
        rd_chk(16'hFFFF, 8'hFF, AV_OKAY);
        program_option(8'h00);
        rd_chk(16'hFFFF, 8'h00, AV_OKAY);
        wr(16'h0032, 8'h00);
        wr(16'h0038, 8'h00);
        cause(C_HW);
        rd_chk(16'h0032, 8'h20, AV_OKAY);
        rd_chk(16'h0038, 8'h41, AV_OKAY);
        rd_chk(16'h001C, 8'h80, AV_OKAY);
        check("jk vdet2 hw on", sfr_regs_jk[SL_VDET_2], 8'h40);
        check("jk vmon1 hw on", sfr_regs_jk[SL_VMON_1], 8'h41);
        program_option(8'hFF);
        wr(16'h0032, 8'h5A);
        wr(16'h0038, 8'h5A);
        wr(16'h001C, 8'h5A);
        cause(C_HW);
        rd_chk(16'h0032, 8'h00, AV_OKAY);
        rd_chk(16'h0038, 8'h00, AV_OKAY);
        rd_chk(16'h001C, 8'h00, AV_OKAY);
        check("jk vdet2 hw off", sfr_regs_jk[SL_VDET_2], 8'h00);
        check("jk vmon1 hw off", sfr_regs_jk[SL_VMON_1], 8'h00);
        $display("test option done");
    endtask

    // software, watchdog and monitor 1 and 2 resets keep the detector state
    task automatic test_soft_resets();
        for (int i = 0; i < 4; i++) begin
            wr(16'h0031, 8'h55);
            wr(16'h0032, 8'h33);
            wr(16'h0036, 8'hF7);
            wr(16'h0038, 8'h5A);
            wr(16'h0004, 8'hA5);
            cause(SOFT[i]);
            rd_chk(16'h0031, 8'h55, AV_OKAY);
            rd_chk(16'h0032, 8'h33, AV_OKAY);
            rd_chk(16'h0036, 8'h04, AV_OKAY);
            rd_chk(16'h0038, 8'h5A, AV_OKAY);
            rd_chk(16'h0004, 8'h00, AV_OKAY);
        end
        cause(C_HW);
        rd_chk(16'h0031, 8'h08, AV_OKAY);
        $display("test soft resets done");
    endtask

    // shared irq byte owned by whichever unit the select bit names
    task automatic test_shared_irq();
        serial_function_select <= 1'b0;
        wr(16'h004F, 8'h03);
        serial_function_select <= 1'b1;
        wr(16'h004F, 8'h05);
        rd_chk(16'h004F, 8'h05, AV_OKAY);
        serial_function_select <= 1'b0;
        rd_chk(16'h004F, 8'h03, AV_OKAY);
        check("ssu slot", sfr_regs[SL_SSU_IRQ], 8'h03);
        check("iic slot", sfr_regs[SL_IIC_IRQ], 8'h05);
        $display("test shared irq done");
    endtask

    // main sequence
    initial begin
        rst_b = 1'b0;
        rst_cause = '0;
        trim_factory = TRIMS;
        prog_we = 1'b0;
        prog_data = 8'h00;
        serial_function_select = 1'b0;
        failures = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        test_reset_values();
        test_gaps();
        test_match_bytes();
        test_option();
        test_soft_resets();
        test_shared_irq();
        wrap_up();
    end
endmodule
`default_nettype wire
